// ==== shared/rfm_pkg.sv ====
// constants, types and register map of the resolver fault monitor
// assumes an apb slave at 20 mhz, 32-bit data, one word per register
//
// Overview of operation
// R1 - loss when amplitude under loss threshold
// R2 - loss when any input pin disconnected
// R3 - loss when any input pin clips rail
// R4 - loss on configuration register parity error
// R5 - loss drives both fault pins low, latched
// R6 - pins released by configuration-mode fault read
// R7 - priority: loss, then degradation, then tracking
// R8 - degradation when amplitude above overrange threshold
// R9 - degradation when max minus min exceeds mismatch
// R10 - track min and max from host initial values
// R11 - degradation latches degrade pin low until cleared
// R12 - monitor is sin products plus cos products
// R13 - monitor updates at master clock over two
// R14 - compare min and max at window end
// R15 - 2 to 4 khz: 1065 internal cycles
// R16 - 4 to 8 khz: 554 internal cycles
// R17 - 8 to 20 khz: 256 internal cycles
// R18 - amplitude faults reported within two windows
// R19 - persistent fault reported again within one window
// R20 - pin code: loss 00, degrade 01, tracking 10
// R21 - clipping also sets fault bit seven
// R22 - read outside configuration mode keeps pins latched
package rfm_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_LOSS      = 8'h88;
    localparam logic [7:0]  IDX_OVER      = 8'h89;
    localparam logic [7:0]  IDX_MISMATCH  = 8'h8a;
    localparam logic [7:0]  IDX_MAX_INIT  = 8'h8b;
    localparam logic [7:0]  IDX_MIN_INIT  = 8'h8c;
    localparam logic [7:0]  IDX_CONTROL   = 8'h92;
    localparam logic [7:0]  IDX_FAULT     = 8'hff;
    localparam int          ADDR_W        = 10;
    localparam int          NUM_CFG       = 5;

    // threshold registers in storage order
    localparam logic [7:0] CFG_IDX [NUM_CFG] = '{
        IDX_LOSS, IDX_OVER, IDX_MISMATCH, IDX_MAX_INIT, IDX_MIN_INIT};
    // bit 7 holds even parity of bits 6:0
    localparam logic [7:0] CFG_RST [NUM_CFG] = '{
        8'h00, 8'hff, 8'hff, 8'h00, 8'hff};
    localparam int CFG_LOSS     = 0;
    localparam int CFG_OVER     = 1;
    localparam int CFG_MISMATCH = 2;
    localparam int CFG_MAX_INIT = 3;
    localparam int CFG_MIN_INIT = 4;

    // control register fields
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam int          CTL_RANGE_LSB = 0;
    localparam int          CTL_CONFIG    = 2;
    localparam logic [1:0]  RANGE_LOW     = 2'h0;
    localparam logic [1:0]  RANGE_MID     = 2'h1;

    // fault register bit positions
    localparam int FLT_CLIP      = 7;
    localparam int FLT_UNDER     = 6;
    localparam int FLT_OVER      = 5;
    localparam int FLT_MISMATCH  = 4;
    localparam int FLT_OPEN      = 3;
    localparam int FLT_TRACK     = 2;
    localparam int FLT_PARITY    = 0;
    localparam logic [7:0] FAULT_RST     = 8'h00;
    localparam logic [7:0] LOSS_MASK     = 8'hc9;
    localparam logic [7:0] DEGRADE_MASK  = 8'h30;

    // window counter periods in internal clock cycles
    localparam logic [10:0] WIN_LOW  = 11'd1065;
    localparam logic [10:0] WIN_MID  = 11'd554;
    localparam logic [10:0] WIN_HIGH = 11'd256;
    localparam int          INT_CLK_DIV = 2;

    // clipping must persist longer than this
    localparam int CLIP_TIME_NS   = 4000;
    localparam int PCLK_PERIOD_NS = 50;
    localparam int CLIP_CYCLES    =
        (CLIP_TIME_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

    // one sample of the resolver inputs and tracked angle
    typedef struct packed {
        logic signed [7:0] sin_in;
        logic signed [7:0] cos_in;
        logic signed [7:0] sin_phi;
        logic signed [7:0] cos_phi;
    } rfm_sample_s;

    // seven-bit threshold values with parity stripped
    typedef struct packed {
        logic [6:0] loss;
        logic [6:0] over;
        logic [6:0] mismatch;
        logic [6:0] max_init;
        logic [6:0] min_init;
    } rfm_thresh_s;

endpackage : rfm_pkg

// ==== rtl/rfm_monitor.sv ====
// demodulated monitor magnitude from one resolver sample
// assumes a one-cycle tick from the internal clock divider
`timescale 1ns/10ps
module rfm_monitor (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // sample in
    input  wire logic               tick,
    input  wire rfm_pkg::rfm_sample_s sample,
    // magnitude out
    output logic [6:0]              mag,
    output logic                    mag_valid
);
    logic signed [15:0] prod_sin;
    logic signed [15:0] prod_cos;
    logic signed [16:0] acc;
    logic        [16:0] mag_full;
    logic         [9:0] scaled;
    logic         [6:0] next_mag;

    // angle terms are q1.7: shift by seven to input scale
    assign prod_sin = sample.sin_in * sample.sin_phi;          // [R12]
    assign prod_cos = sample.cos_in * sample.cos_phi;          // [R12]
    assign acc      = {prod_sin[15], prod_sin}
                    + {prod_cos[15], prod_cos};                // [R12]
    assign mag_full = acc[16] ? 17'(-acc) : 17'(acc);
    assign scaled   = mag_full[16:7];
    // saturate rather than wrap so a large input never reads small
    assign next_mag = (|scaled[9:7]) ? 7'h7f : scaled[6:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mag       <= 7'h00;
            mag_valid <= 1'b0;
        end else begin
            mag_valid <= tick;                                 // [R13]
            if (tick) begin
                mag <= next_mag;                               // [R13]
            end
        end
    end
endmodule : rfm_monitor

// ==== rtl/rfm_fault_monitor.sv ====
// fault supervision: monitor min/max, window compare, latched fault pins
// assumes apb master on pclk; analog detectors arrive as sync levels
`timescale 1ns/10ps
module rfm_fault_monitor (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [rfm_pkg::ADDR_W-1:0] paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // resolver side
    input  wire rfm_pkg::rfm_sample_s sample,
    input  wire logic [3:0]           pin_open,
    input  wire logic [3:0]           pin_clip,
    input  wire logic                 tracking_loss_fault,
    // fault pins
    output logic                      degrade_fault_n,
    output logic                      tracking_fault_n
);
    // register storage
    logic [7:0]  cfg_reg [rfm_pkg::NUM_CFG];
    logic [7:0]  control;
    logic [7:0]  fault_status;
    rfm_pkg::rfm_thresh_s thresh;

    // bus decode
    logic [7:0]  bus_idx;
    logic        addr_aligned;
    logic        setup_phase;
    logic        access_phase;
    logic        wr_access;
    logic        rd_access;
    logic        hit_control;
    logic        hit_fault;
    logic [rfm_pkg::NUM_CFG-1:0] hit_cfg;
    logic        mapped;
    logic [7:0]  rd_mux;
    logic [7:0]  read_snapshot;

    // mode and window
    logic        config_mode;
    logic [1:0]  exc_range;
    logic        int_phase;
    logic        int_tick;
    logic [10:0] win_count;
    logic [10:0] win_period;
    logic        win_end;

    // monitor statistics
    logic [6:0]  mag;
    logic        mag_valid;
    logic [6:0]  cur_min;
    logic [6:0]  cur_max;
    logic [6:0]  spread;

    // detectors
    logic [rfm_pkg::NUM_CFG-1:0] parity_bad;
    logic        any_parity_bad;
    logic        any_clip;
    logic [7:0]  clip_count;
    logic        clip_long;
    logic        under_hit;
    logic        over_hit;
    logic        mismatch_hit;
    logic [7:0]  fault_set;
    logic [7:0]  fault_clear;
    logic        read_clear;
    logic        loss_active;
    logic        degrade_active;
    logic        next_degrade_n;
    logic        next_tracking_n;

    // apb decode: index is the word address
    assign bus_idx      = paddr[9:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign hit_control  = addr_aligned && (bus_idx == rfm_pkg::IDX_CONTROL);
    assign hit_fault    = addr_aligned && (bus_idx == rfm_pkg::IDX_FAULT);
    assign mapped       = hit_control || hit_fault || (|hit_cfg);
    assign wr_access    = access_phase && pwrite;
    assign rd_access    = access_phase && !pwrite;
    // zero wait states; unmapped or read-only writes fail
    assign pready       = 1'b1;
    assign pslverr      = access_phase
                        && (!mapped || (pwrite && hit_fault));

    // control fields
    assign exc_range   = control[rfm_pkg::CTL_RANGE_LSB +: 2];
    assign config_mode = control[rfm_pkg::CTL_CONFIG];

    // one slot per register, parity kept as written
    genvar gi;
    generate
        for (gi = 0; gi < rfm_pkg::NUM_CFG; gi++) begin : g_cfg
            assign hit_cfg[gi] = addr_aligned
                && (bus_idx == rfm_pkg::CFG_IDX[gi]);
            // bit 7 is even parity of bits 6:0
            assign parity_bad[gi] = ^cfg_reg[gi];               // [R4]
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_reg[gi] <= rfm_pkg::CFG_RST[gi];
                end else if (wr_access && hit_cfg[gi]) begin
                    cfg_reg[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate
    assign any_parity_bad = |parity_bad;

    assign thresh.loss     = cfg_reg[rfm_pkg::CFG_LOSS][6:0];
    assign thresh.over     = cfg_reg[rfm_pkg::CFG_OVER][6:0];
    assign thresh.mismatch = cfg_reg[rfm_pkg::CFG_MISMATCH][6:0];
    assign thresh.max_init = cfg_reg[rfm_pkg::CFG_MAX_INIT][6:0];
    assign thresh.min_init = cfg_reg[rfm_pkg::CFG_MIN_INIT][6:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= rfm_pkg::CONTROL_RST;
        end else if (wr_access && hit_control) begin
            control <= pwdata[7:0];
        end
    end

    // read mux; data captured in setup so it is stable in access
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < rfm_pkg::NUM_CFG; i++) begin
            if (hit_cfg[i]) begin
                rd_mux = cfg_reg[i];
            end
        end
        if (hit_control) begin
            rd_mux = control;
        end
        if (hit_fault) begin
            rd_mux = fault_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h0000_0000;
            read_snapshot <= 8'h00;
        end else if (setup_phase && !pwrite) begin
            prdata        <= {24'h00_0000, rd_mux};
            read_snapshot <= hit_fault ? fault_status : 8'h00;
        end
    end

    // internal clock: one tick every second pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_phase <= 1'b0;
        end else begin
            int_phase <= !int_phase;                           // [R13]
        end
    end
    assign int_tick = int_phase;                               // [R13]

    // window counter period from the excitation range
    assign win_period = (exc_range == rfm_pkg::RANGE_LOW) ? rfm_pkg::WIN_LOW
                      : (exc_range == rfm_pkg::RANGE_MID) ? rfm_pkg::WIN_MID
                      : rfm_pkg::WIN_HIGH;     // [R15] [R16] [R17]
    // >= so a shorter range chosen mid-window ends it at once
    assign win_end = int_tick
                  && (win_count >= win_period - 11'd1);        // [R14]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_count <= 11'd0;
        end else if (win_end) begin
            win_count <= 11'd0;
        end else if (int_tick) begin
            win_count <= win_count + 11'd1; // [R15] [R16] [R17]
        end
    end

    rfm_monitor u_monitor (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (int_tick),
        .sample    (sample),
        .mag       (mag),
        .mag_valid (mag_valid)
    );

    // running min and max, restarted from host values each window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_min <= 7'h7f;
            cur_max <= 7'h00;
        end else if (win_end) begin
            cur_min <= thresh.min_init;                        // [R10]
            cur_max <= thresh.max_init;                        // [R10]
        end else if (mag_valid) begin
            if (mag < cur_min) begin
                cur_min <= mag;                                // [R10]
            end
            if (mag > cur_max) begin
                cur_max <= mag;                                // [R10]
            end
        end
    end

    // window-end comparisons; fresh stats each window bound latency
    assign spread       = (cur_max > cur_min) ? cur_max - cur_min : 7'h00;
    assign under_hit    = win_end && (cur_min < thresh.loss);      // [R1] [R18]
    assign over_hit     = win_end && (cur_max > thresh.over);      // [R8] [R18]
    assign mismatch_hit = win_end && (spread > thresh.mismatch);   // [R9]

    // clipping must outlast the persistence time
    assign any_clip  = |pin_clip;
    assign clip_long = any_clip
                    && (clip_count >= 8'(rfm_pkg::CLIP_CYCLES));   // [R3]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clip_count <= 8'h00;
        end else if (!any_clip) begin
            clip_count <= 8'h00;
        end else if (!clip_long) begin
            clip_count <= clip_count + 8'h01;
        end
    end

    // sticky fault bits
    always_comb begin
        fault_set = 8'h00;
        fault_set[rfm_pkg::FLT_CLIP]     = clip_long;          // [R3] [R21]
        fault_set[rfm_pkg::FLT_UNDER]    = under_hit;          // [R1]
        fault_set[rfm_pkg::FLT_OVER]     = over_hit;           // [R8]
        fault_set[rfm_pkg::FLT_MISMATCH] = mismatch_hit;       // [R9]
        fault_set[rfm_pkg::FLT_OPEN]     = |pin_open;          // [R2]
        fault_set[rfm_pkg::FLT_TRACK]    = tracking_loss_fault;
        fault_set[rfm_pkg::FLT_PARITY]   = any_parity_bad;     // [R4]
    end

    // only config-mode reads clear, and only bits returned
    assign read_clear  = rd_access && hit_fault && config_mode;    // [R6] [R22]
    assign fault_clear = read_clear ? read_snapshot : 8'h00;       // [R6]

    // a live condition re-sets at once or at the next window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_status <= rfm_pkg::FAULT_RST;
        end else begin
            fault_status <= (fault_status & ~fault_clear)
                          | fault_set;                         // [R19]
        end
    end

    // latched pin states; tracking loss follows its live level
    assign loss_active    = |(fault_status & rfm_pkg::LOSS_MASK);      // [R5]
    assign degrade_active = |(fault_status & rfm_pkg::DEGRADE_MASK);   // [R11]
    assign next_degrade_n  = !(loss_active || degrade_active); // [R5][R11][R20]
    assign next_tracking_n = !(loss_active                     // [R7] [R20]
                          || (!degrade_active && tracking_loss_fault));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            degrade_fault_n  <= 1'b1;
            tracking_fault_n <= 1'b1;
        end else begin
            degrade_fault_n  <= next_degrade_n;                // [R7]
            tracking_fault_n <= next_tracking_n;               // [R7]
        end
    end
endmodule : rfm_fault_monitor

// ==== testbench/rfm_resolver_model.sv ====
// resolver secondaries and detector levels facing the fault monitor
// assumes the bench sets amplitude and fault modes at pclk edges
`timescale 1ns/10ps
module rfm_resolver_model #(
    parameter logic signed [7:0] PHI = 8'sh5a
) (
    // clock
    input  wire logic              pclk,
    // bench settings
    input  wire logic signed [7:0] amp,
    input  wire logic [3:0]        open_req,
    input  wire logic [3:0]        clip_req,
    input  wire logic              track_req,
    // towards the monitor
    output rfm_pkg::rfm_sample_s   sample,
    output logic [3:0]             pin_open,
    output logic [3:0]             pin_clip,
    output logic                   tracking_loss_fault
);
    // matched windings, loop tracking at 45 degrees
    // levels move on pclk edges only
    always_ff @(posedge pclk) begin
        sample              <= {amp, amp, PHI, PHI};
        pin_open            <= open_req;
        pin_clip            <= clip_req;
        tracking_loss_fault <= track_req;
    end
endmodule : rfm_resolver_model

// ==== testbench/rfm_fault_monitor_asserts.sv ====
// port-level checks of the resolver fault monitor
// assumes a bind onto rfm_fault_monitor, one clock domain
`timescale 1ns/10ps
module rfm_fault_monitor_asserts (
    // clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // apb
    input wire logic [rfm_pkg::ADDR_W-1:0]  paddr,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // resolver side and pins
    input wire rfm_pkg::rfm_sample_s        sample,
    input wire logic [3:0]                  pin_open,
    input wire logic [3:0]                  pin_clip,
    input wire logic                        tracking_loss_fault,
    input wire logic                        degrade_fault_n,
    input wire logic                        tracking_fault_n
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire flt_rd = acc && !pwrite && paddr == {rfm_pkg::IDX_FAULT, 2'b00};
    wire cfg_wr = acc && pwrite && paddr[1:0] == 2'b00
        && paddr[9:2] >= rfm_pkg::IDX_LOSS
        && paddr[9:2] <= rfm_pkg::IDX_MIN_INIT;
    wire bad_par = pwdata[7] != ^pwdata[6:0];
    wire both_low = !degrade_fault_n && !tracking_fault_n;
    logic cfg_mode;
    logic [6:0] clip_cnt;
    wire clr_rd = flt_rd && cfg_mode;
    // shadow of the configuration-mode bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_mode <= 1'b0;
        end else if (acc && pwrite && paddr[9:2] == rfm_pkg::IDX_CONTROL) begin
            cfg_mode <= pwdata[rfm_pkg::CTL_CONFIG];
        end
    end
    // saturating run length of clipping, too long for a repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clip_cnt <= 7'h00;
        end else if (pin_clip == 4'h0) begin
            clip_cnt <= 7'h00;
        end else if (clip_cnt != 7'h7f) begin
            clip_cnt <= clip_cnt + 7'h01;
        end
    end
    a_open_loss: assert property (
        pin_open != 4'h0 |-> ##[1:3] both_low)
        else $error("open input did not latch both pins");
    a_clip_loss: assert property (
        clip_cnt == 7'h5a |-> both_low)
        else $error("long clipping did not latch both pins");
    a_clip_bit: assert property (
        clip_cnt > 7'h5a && flt_rd |-> prdata[rfm_pkg::FLT_CLIP])
        else $error("clipping bit missing from fault read");
    a_parity_loss: assert property (
        cfg_wr && bad_par |-> ##[1:4] both_low)
        else $error("bad parity did not latch both pins");
    a_latch_hold: assert property (
        $rose(degrade_fault_n) |-> $past(clr_rd, 2) || $past(clr_rd))
        else $error("degrade pin released without config read");
    a_track_pin: assert property (
        tracking_loss_fault [*3] ##0 degrade_fault_n |-> !tracking_fault_n)
        else $error("tracking pin high during tracking loss");
    a_reset_pins: assert property (
        $rose(presetn) |-> degrade_fault_n && tracking_fault_n)
        else $error("pins not idle after reset");
    a_ro_fault: assert property (
        acc && pwrite && paddr == {rfm_pkg::IDX_FAULT, 2'b00} |-> pslverr)
        else $error("write to fault register not refused");
    a_word_bus: assert property (
        pready && prdata[31:8] == 24'h00_0000)
        else $error("bus answer or upper read bits wrong");
endmodule : rfm_fault_monitor_asserts
bind rfm_fault_monitor rfm_fault_monitor_asserts u_asserts (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .sample, .pin_open, .pin_clip, .tracking_loss_fault,
    .degrade_fault_n, .tracking_fault_n);

// ==== testbench/test_rfm_fault_monitor.sv ====
// self-checking bench of the resolver fault monitor over apb
// assumes the resolver model and the bound checker beside it
`timescale 1ns/10ps
module test_rfm_fault_monitor;
    localparam logic [9:0] A_LOSS = {rfm_pkg::IDX_LOSS, 2'b00};
    localparam logic [9:0] A_OVER = {rfm_pkg::IDX_OVER, 2'b00};
    localparam logic [9:0] A_MIS  = {rfm_pkg::IDX_MISMATCH, 2'b00};
    localparam logic [9:0] A_MAX  = {rfm_pkg::IDX_MAX_INIT, 2'b00};
    localparam logic [9:0] A_CTL  = {rfm_pkg::IDX_CONTROL, 2'b00};
    localparam logic [9:0] A_FLT  = {rfm_pkg::IDX_FAULT, 2'b00};
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic [9:0]           paddr = 10'h000;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 degrade_fault_n;
    logic                 tracking_fault_n;
    rfm_pkg::rfm_sample_s sample;
    logic [3:0]           pin_open;
    logic [3:0]           pin_clip;
    logic                 tracking_loss_fault;
    logic signed [7:0]    amp = 8'sh32;
    logic [3:0]           open_req = 4'h0;
    logic [3:0]           clip_req = 4'h0;
    logic                 track_req = 1'b0;
    logic [15:0]          lfsr_q = 16'h0001;
    logic [31:0]          rd_q;
    logic                 err_q;
    int                   num_errors = 0;
    int                   n_checks = 0;
    rfm_resolver_model u_model (.pclk, .amp, .open_req, .clip_req,
        .track_req, .sample, .pin_open, .pin_clip, .tracking_loss_fault);
    rfm_fault_monitor uut (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .sample, .pin_open,
        .pin_clip, .tracking_loss_fault, .degrade_fault_n, .tracking_fault_n);
    initial begin
        forever #25 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // threshold word, even parity in bit 7
    function automatic logic [31:0] par(input logic [6:0] v);
        return {24'h00_0000, ^v, v};
    endfunction : par
    // products over 128; model phi terms are 90
    function automatic int mag_of(input int s, input int c);
        int v;
        v = (s * 90 + c * 90) >>> 7;
        return (v < 0) ? -v : v;
    endfunction : mag_of
    function automatic int win_of(input int r);
        if (r == 0) return int'(rfm_pkg::WIN_LOW);
        if (r == 1) return int'(rfm_pkg::WIN_MID);
        return int'(rfm_pkg::WIN_HIGH);
    endfunction : win_of
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic [9:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        apb(a, 1'b0, 32'h0000_0000);
        chk(rd_q, {24'h00_0000, e});
    endtask : rd
    // zero limit: sample the pins once
    task automatic pins(input logic [1:0] code, input int lim);
        int n;
        n = 0;
        while ({degrade_fault_n, tracking_fault_n} !== code && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({30'h0, degrade_fault_n, tracking_fault_n}, {30'h0, code});
    endtask : pins
    initial begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
    initial begin
        int m;
        int w;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < rfm_pkg::NUM_CFG; i++) begin
            rd({rfm_pkg::CFG_IDX[i], 2'b00}, rfm_pkg::CFG_RST[i]);
            lfsr_q = lfsr(lfsr_q);
            apb({rfm_pkg::CFG_IDX[i], 2'b00}, 1'b1, par(lfsr_q[6:0]));
            rd({rfm_pkg::CFG_IDX[i], 2'b00}, {^lfsr_q[6:0], lfsr_q[6:0]});
            apb({rfm_pkg::CFG_IDX[i], 2'b00}, 1'b1, rfm_pkg::CFG_RST[i]);
        end
        rd(A_CTL, rfm_pkg::CONTROL_RST);
        apb(10'h3f8, 1'b0, 32'h0000_0000);
        chk({31'h0, err_q}, 32'h0000_0001);
        apb(A_FLT, 1'b1, 32'h0000_00ff);
        chk({31'h0, err_q}, 32'h0000_0001);
        // random matched amplitude sets the loss boundary
        lfsr_q = lfsr(lfsr_q);
        amp <= 8'sd20 + $signed({2'b00, lfsr_q[5:0]});
        @(posedge pclk);
        m = mag_of(amp, amp);
        apb(A_LOSS, 1'b1, par(m[6:0]));
        apb(A_CTL, 1'b1, 32'h0000_0004);
        apb(A_FLT, 1'b0, 32'h0000_0000);
        for (int r = 0; r < 3; r++) begin
            w = 2 * win_of(r);
            apb(A_CTL, 1'b1, r);
            repeat (2 * w + 4) @(posedge pclk);
            pins(2'b11, 0);
            apb(A_LOSS, 1'b1, par(m[6:0] + 7'h01));
            pins(2'b00, 2 * w + 4);
            rd(A_FLT, 8'h40);
            pins(2'b00, 0);
            apb(A_CTL, 1'b1, 32'h0000_0004 | r);
            rd(A_FLT, 8'h40);
            pins(2'b11, 3);
            pins(2'b00, w + 4);
            apb(A_LOSS, 1'b1, par(m[6:0]));
            apb(A_FLT, 1'b0, 32'h0000_0000);
            repeat (w + 4) @(posedge pclk);
            pins(2'b11, 0);
        end
        apb(A_OVER, 1'b1, par(m[6:0] - 7'h01));
        pins(2'b01, 1030);
        track_req <= 1'b1;
        repeat (8) @(posedge pclk);
        pins(2'b01, 0);
        open_req <= 4'h1;
        pins(2'b00, 8);
        open_req <= 4'h0;
        track_req <= 1'b0;
        apb(A_OVER, 1'b1, par(7'h7f));
        rd(A_FLT, 8'h2c);
        pins(2'b11, 3);
        track_req <= 1'b1;
        pins(2'b10, 8);
        track_req <= 1'b0;
        pins(2'b11, 8);
        apb(A_MAX, 1'b1, par(m[6:0] + 7'h05));
        apb(A_MIS, 1'b1, par(7'h05));
        apb(A_FLT, 1'b0, 32'h0000_0000);
        repeat (1030) @(posedge pclk);
        pins(2'b11, 0);
        apb(A_MIS, 1'b1, par(7'h04));
        pins(2'b01, 1030);
        apb(A_MIS, 1'b1, par(7'h7f));
        apb(A_MAX, 1'b1, par(7'h00));
        rd(A_FLT, 8'h10);
        clip_req <= 4'h2;
        pins(2'b00, 100);
        repeat (10) @(posedge pclk);
        rd(A_FLT, 8'h80);
        clip_req <= 4'h0;
        apb(A_FLT, 1'b0, 32'h0000_0000);
        pins(2'b11, 3);
        // bad parity, then a mid-run reset to recover
        apb(A_LOSS, 1'b1, 32'h0000_0001);
        pins(2'b00, 8);
        rd(A_FLT, 8'h01);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        pins(2'b11, 0);
        rd(A_LOSS, rfm_pkg::CFG_RST[rfm_pkg::CFG_LOSS]);
        give_verdict();
    end
endmodule : test_rfm_fault_monitor
